// [verilog/fbio_map.vh]
// register map and reset values for the five-pin i/o port
// assumes: included by the port design file, byte-wide register port
`ifndef FBIO_MAP_VH
`define FBIO_MAP_VH

`define FBIO_ADDR_W         16
`define FBIO_DATA_ADDR      16'hFFDA
`define FBIO_DIR_ADDR       16'hFFEA
`define FBIO_DATA_RESET     8'h00
`define FBIO_DIR_RESET      8'h00
`define FBIO_DIR_READ_VALUE 8'hFF
`define FBIO_PIN_LSB        3
`define FBIO_PIN_MSB        7
`define FBIO_PIN_COUNT      5
`define FBIO_RSVD_MASK      8'hF8

`endif

// [verilog/fbio_port.v]
// five-pin general-purpose i/o port, pins on bits 7 down to 3
// assumes: one clk_sys domain, a cpu register port whose read data
// follow the read strobe by one cycle, pins driven through separate
// out and enable lines, and pin levels asynchronous to clk_sys; the
// clock enable freezes every flip-flop of the block while it is low
//
// Function
// - data register holds output values for pins at bits 7 to 3
// - data bits 2 to 0 read as zero and ignore writes
// - direction one: port read returns stored data bit
// - direction zero: port read returns sampled pin level
// - direction one makes pin an output, zero an input
// - reset clears the data register to zero
// - reset clears the direction register, all pins inputs
// - direction register is write-only and reads all ones
// - data register at FFDA, direction register at FFEA, byte wide

`timescale 1ns/10ps
`default_nettype none

`include "fbio_map.vh"

module fbio_port (
  // clock, reset and freeze
  input  wire                    clk_sys,
  input  wire                    rst_n,
  input  wire                    clk_en,

  // cpu register port
  input  wire [`FBIO_ADDR_W-1:0] reg_addr,
  input  wire [7:0]              reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [7:0]              reg_rdata,

  // pins, bit 0 is port bit 3
  input  wire [4:0]              pin_in,
  output wire [4:0]              pin_out,
  output wire [4:0]              pin_oe
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  // pin field of the register byte
  localparam integer ADDR_W    = `FBIO_ADDR_W;
  localparam integer PIN_LSB   = `FBIO_PIN_LSB;
  localparam integer PIN_MSB   = `FBIO_PIN_MSB;
  localparam integer PIN_COUNT = `FBIO_PIN_COUNT;

  // register addresses
  localparam [ADDR_W-1:0] DATA_ADDR = `FBIO_DATA_ADDR;
  localparam [ADDR_W-1:0] DIR_ADDR  = `FBIO_DIR_ADDR;

  // reset and read-back values
  localparam [7:0] DATA_RESET_BYTE = `FBIO_DATA_RESET;
  localparam [7:0] DIR_RESET_BYTE  = `FBIO_DIR_RESET;
  localparam [7:0] DIR_READ_BYTE   = `FBIO_DIR_READ_VALUE;
  localparam [7:0] RSVD_MASK       = `FBIO_RSVD_MASK;
  localparam [7:0] IDLE_BYTE       = 8'h00;

  localparam [PIN_COUNT-1:0] DATA_RESET = DATA_RESET_BYTE[PIN_MSB:PIN_LSB];
  localparam [PIN_COUNT-1:0] DIR_RESET  = DIR_RESET_BYTE[PIN_MSB:PIN_LSB];

  // write target select, binary coded
  localparam [1:0] WR_NONE = 2'h0;
  localparam [1:0] WR_DATA = 2'h1;
  localparam [1:0] WR_DIR  = 2'h2;

  // read source select, binary coded
  localparam [1:0] RD_NONE = 2'h0;
  localparam [1:0] RD_DATA = 2'h1;
  localparam [1:0] RD_DIR  = 2'h2;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function is_addr;
    input [ADDR_W-1:0] a;
    input [ADDR_W-1:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // pin field of a register byte; the reserved low bits fall away here
  function [PIN_COUNT-1:0] pin_field;
    input [7:0] byte_in;
    begin
      pin_field = byte_in[PIN_MSB:PIN_LSB];
    end
  endfunction

  // pin field back into byte position with the reserved bits at zero
  function [7:0] pin_byte;
    input [PIN_COUNT-1:0] field;
    begin
      pin_byte = {field, 3'h0} & RSVD_MASK;
    end
  endfunction

  // register that a write strobe lands in
  function [1:0] write_target;
    input [ADDR_W-1:0] addr;
    begin
      if (is_addr(addr, DATA_ADDR)) begin
        write_target = WR_DATA;
      end else if (is_addr(addr, DIR_ADDR)) begin
        write_target = WR_DIR;
      end else begin
        write_target = WR_NONE;
      end
    end
  endfunction

  // register that a read strobe addresses
  function [1:0] read_source;
    input [ADDR_W-1:0] addr;
    begin
      if (is_addr(addr, DATA_ADDR)) begin
        read_source = RD_DATA;
      end else if (is_addr(addr, DIR_ADDR)) begin
        read_source = RD_DIR;
      end else begin
        read_source = RD_NONE;
      end
    end
  endfunction

  // value a read shows for one pin
  function pin_read;
    input dir_bit_in;
    input data_bit_in;
    input level_in;
    begin
      if (dir_bit_in) begin
        pin_read = data_bit_in;
      end else begin
        pin_read = level_in;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // bus strobes
  // ----------------------------------------------------------------
  wire       take_wr;
  wire       take_rd;
  reg  [1:0] wr_sel;
  reg        wr_data;
  reg        wr_dir;
  reg  [1:0] rd_sel;

  // a frozen block takes no strobe, so nothing is half done on resume
  assign take_wr = reg_wr & clk_en;
  assign take_rd = reg_rd & clk_en;

  always @* begin
    if (take_wr) begin
      wr_sel = write_target(reg_addr);
    end else begin
      wr_sel = WR_NONE;
    end
  end

  // unmapped addresses select WR_NONE and change nothing
  always @* begin
    case (wr_sel)
      WR_DATA: begin
        wr_data = 1'h1;
        wr_dir  = 1'h0;
      end
      WR_DIR: begin
        wr_data = 1'h0;
        wr_dir  = 1'h1;
      end
      WR_NONE: begin
        wr_data = 1'h0;
        wr_dir  = 1'h0;
      end
      default: begin
        wr_data = 1'h0;
        wr_dir  = 1'h0;
      end
    endcase
  end

  always @* begin
    if (take_rd) begin
      rd_sel = read_source(reg_addr);
    end else begin
      rd_sel = RD_NONE;
    end
  end

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  wire [PIN_COUNT-1:0] port_output_data;
  wire [PIN_COUNT-1:0] port_direction_control;
  reg  [PIN_COUNT-1:0] next_port_output_data;
  reg  [PIN_COUNT-1:0] next_port_direction_control;
  wire [PIN_COUNT-1:0] pin_sync;
  wire [PIN_COUNT-1:0] port_view;
  reg  [7:0]           next_reg_rdata;

  always @* begin
    if (wr_data) begin
      // only the pin field is kept, so reserved bits stay zero
      next_port_output_data = pin_field(reg_wdata);
    end else begin
      next_port_output_data = port_output_data;
    end
  end

  always @* begin
    if (wr_dir) begin
      next_port_direction_control = pin_field(reg_wdata);
    end else begin
      next_port_direction_control = port_direction_control;
    end
  end

  // ----------------------------------------------------------------
  // per-pin storage
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_store
      reg data_bit;
      reg dir_bit;

      // stored output value of this pin
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          data_bit <= DATA_RESET[i];
        end else if (clk_en) begin
          data_bit <= next_port_output_data[i];
        end
      end

      // direction of this pin; all pins come out of reset as inputs
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          dir_bit <= DIR_RESET[i];
        end else if (clk_en) begin
          dir_bit <= next_port_direction_control[i];
        end
      end

      assign port_output_data[i]       = data_bit;
      assign port_direction_control[i] = dir_bit;
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_sync
      reg meta_bit;
      reg sync_bit;

      // first stage may go metastable; only the second stage reads it
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          meta_bit <= 1'h0;
        end else if (clk_en) begin
          meta_bit <= pin_in[i];
        end
      end

      // frozen with the rest of the block while clk_en is low
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          sync_bit <= 1'h0;
        end else if (clk_en) begin
          sync_bit <= meta_bit;
        end
      end

      assign pin_sync[i] = sync_bit;
    end
  endgenerate

  // ----------------------------------------------------------------
  // read view
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_view
      // a changing input pin shows up two enabled edges late
      assign port_view[i] = pin_read(port_direction_control[i],
                                     port_output_data[i],
                                     pin_sync[i]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < PIN_COUNT; i = i + 1) begin : g_drive
      // drive only while the direction bit selects output
      assign pin_oe[i]  = port_direction_control[i];
      assign pin_out[i] = port_output_data[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // read data, valid the cycle after the strobe only
  // ----------------------------------------------------------------
  always @* begin
    case (rd_sel)
      RD_DATA: begin
        next_reg_rdata = pin_byte(port_view);
      end
      RD_DIR: begin
        // write-only register: the stored direction is never visible
        next_reg_rdata = DIR_READ_BYTE;
      end
      RD_NONE: begin
        next_reg_rdata = IDLE_BYTE;
      end
      default: begin
        next_reg_rdata = IDLE_BYTE;
      end
    endcase
  end

  // idle value between reads, so a stale byte is never seen twice
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= IDLE_BYTE;
    end else if (clk_en) begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

`default_nettype wire

// [tb/fbio_checker.sv]
// checker: register and pin relations at the fbio_port ports
`timescale 1ns/10ps
`default_nettype none
module fbio_checker (input wire logic clk_sys, rst_n, clk_en, reg_wr, reg_rd,
  input wire logic [15:0] reg_addr, input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata, input wire logic [4:0] pin_out, pin_oe);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire dsel = clk_en && reg_addr == 16'hFFDA;
  wire csel = clk_en && reg_addr == 16'hFFEA;
  a_dir_set: assert property (csel && reg_wr |=> pin_oe == $past(reg_wdata[7:3])) else $error("dir write");
  a_out_set: assert property (dsel && reg_wr |=> pin_out == $past(reg_wdata[7:3])) else $error("data write");
  a_dir_ones: assert property (csel && reg_rd |=> reg_rdata == 8'hFF) else $error("dir read");
  a_rsvd_zero: assert property (dsel && reg_rd |=> reg_rdata[2:0] == 3'h0) else $error("low bits");
  a_out_view: assert property (dsel && reg_rd |=> ((reg_rdata[7:3] ^ $past(pin_out)) & $past(pin_oe)) == 5'h00) else $error("view");
  a_dir_hold: assert property (!(csel && reg_wr) |=> $stable(pin_oe)) else $error("dir hold");
  a_rst_clear: assert property ($rose(rst_n) |-> pin_oe == 5'h00 && pin_out == 5'h00) else $error("reset");
  a_rd_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 8'h00) else $error("idle");
  a_freeze_hold: assert property (!clk_en |=> $stable(pin_oe) && $stable(pin_out)) else $error("freeze");
endmodule
bind fbio_port fbio_checker chk_u (.*);
`default_nettype wire

// [tb/fbio_pins.sv]
// far side: a pin reads back its driven value, else the board level
`timescale 1ns/10ps
`default_nettype none
module fbio_pins (input wire logic [4:0] pin_out, pin_oe, ext,
  output wire logic [4:0] pin_in);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// [tb/tb_five_bit_io_port.sv]
// bench: register accesses, pin checks, clock-enable freeze, mid-run reset
`timescale 1ns/10ps
`default_nettype none
module tb_five_bit_io_port;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [4:0] pin_in, pin_out, pin_oe, ext = 5'h15;
  int mismatches = 0, cmp_count = 0;
  always #12.5 clk_sys = ~clk_sys;
  fbio_port dut_u (.clk_sys, .rst_n, .clk_en, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out, .pin_oe);
  fbio_pins pins_u (.pin_out, .pin_oe, .ext, .pin_in);
  task chk(logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  // a read compares against d, a write stores d
  task acc(logic w, logic [15:0] a, logic [7:0] d);
    @(posedge clk_sys) {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge clk_sys) {reg_wr, reg_rd} <= 2'b00;
    #1 if (!w) chk(reg_rdata, d);
  endtask
  task t_mixed;
    acc(0, 16'hFFDA, 8'h00);
    acc(0, 16'hFFEA, 8'hFF);
    acc(1, 16'hFFEA, 8'hC7);
    acc(1, 16'hFFDA, 8'h57);
    chk({pin_oe & pin_out, 3'h0}, 8'h40);
    acc(0, 16'hFFDA, 8'h68);
  endtask
  task t_input;
    acc(1, 16'hFFEA, 8'h00);
    // input view lags the pins through the synchroniser
    repeat (3) @(posedge clk_sys);
    acc(0, 16'hFFDA, 8'hA8);
    acc(0, 16'h0000, 8'h00);
  endtask
  // a write while frozen must be lost
  task t_freeze;
    acc(1, 16'hFFEA, 8'hF8);
    @(posedge clk_sys) clk_en <= 1'b0;
    acc(1, 16'hFFDA, 8'hF8);
    @(posedge clk_sys) clk_en <= 1'b1;
    acc(0, 16'hFFDA, 8'h50);
  endtask
  task t_reset;
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({pin_oe, 3'h0}, 8'h00);
    chk({pin_out, 3'h0}, 8'h00);
    acc(1, 16'hFFEA, 8'hF8);
    acc(0, 16'hFFDA, 8'h00);
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_mixed;
    t_input;
    t_freeze;
    t_reset;
    test_done;
  end
  initial begin
    #5000 mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
